/* logic/pcih_top.sv */
// configuration header built from the static configuration-port inputs, the code parameters and host-written fields
`timescale 1ns/100ps
`include "pcih_cfg.svh"
module pcih_top
  import pcih_pkg::*;
#(
  parameter logic [15:0] VENDOR_CODE    = 16'h1234, // arbitrary value
  parameter logic [15:0] DEVICE_CODE    = 16'h0001, // arbitrary value
  parameter logic [15:0] SUB_VENDOR_CODE = 16'h1234, // arbitrary value
  parameter logic [15:0] SUB_DEVICE_CODE = 16'h0001  // arbitrary value
)
(
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  // configuration access from the pci host
  input  wire logic        cfg_rd_in,
  input  wire logic        cfg_wr_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [3:0]  cfg_be_in,
  input  wire logic [31:0] cfg_wdata_in,
  output logic [31:0]      cfg_rdata_out,
  output logic             cfg_ack_out,
  // bus command decode
  input  wire logic        cmd_valid_in,
  input  wire logic [3:0]  bus_cmd_in,
  output logic             iack_claim_out,
  // interrupt
  input  wire logic        l_interrupt_n_in,
  output logic             inta_out,
  output logic             inta_oe_out,
  // configuration-port inputs
  input  wire logic [7:0]  revision_code_input,
  input  wire logic [23:0] class_code_in,
  input  wire logic [1:0]  decode_speed_in,
  input  wire logic        cap_list_ena_in,
  input  wire logic [7:0]  cap_ptr_in,
  input  wire logic [31:0] cis_ptr_in,
  input  wire logic        back_to_back_capable_input,
  input  wire logic        iack_ena_in,
  input  wire logic [7:0]  int_pin_in,
  input  wire logic [7:0]  hw_lat_timer_in,
  input  wire logic        hw_lat_timer_ena_in,
  input  wire logic [7:0]  min_grant_in,
  input  wire logic [7:0]  max_latency_in,
  input  wire logic        fast_clock_capable_input,
  input  wire logic [5:0]  wide_data_select_input,
  input  wire logic [31:0] base_address_def_0,
  input  wire logic [31:0] base_address_def_1,
  input  wire logic [31:0] base_address_def_2,
  input  wire logic [31:0] base_address_def_3,
  input  wire logic [31:0] base_address_def_4,
  input  wire logic [31:0] base_address_def_5,
  output logic [5:0]       bar_wide_out
);
  // request sequencing and stored header fields
  pcih_state_t state_q;
  pcih_state_t state_d;
  logic        take;
  logic [7:0]  word_addr;
  logic [15:0] command_q;
  logic [7:0]  lat_timer_q;
  logic [7:0]  cache_line_q;
  logic [7:0]  int_line_q;
  logic [15:0] status_w;
  pcih_word_t  rd_word;
  pcih_word_t  bar_def [6];
  pcih_word_t  bar_rd  [6];
  logic [5:0]  bar_wr;
  logic        rd_take;
  logic        wr_take;
  logic        wr_cmd;
  logic        wr_misc;
  logic        wr_intr;
  logic [7:0]  lat_timer_rd;
  pcih_word_t  cmd_merged;
  pcih_word_t  id_word;
  pcih_word_t  cmdstat_word;
  pcih_word_t  class_word;
  pcih_word_t  misc_word;
  pcih_word_t  subsys_word;
  pcih_word_t  cap_word;
  pcih_word_t  intr_word;

  // true when the request addresses the given header word
  function automatic logic word_hit(input logic [7:0] a, input logic [7:0] off);
    word_hit = ({a[7:2], 2'b00} == off);
  endfunction : word_hit

  // definition inputs gathered for indexing
  assign bar_def[0] = base_address_def_0;
  assign bar_def[1] = base_address_def_1;
  assign bar_def[2] = base_address_def_2;
  assign bar_def[3] = base_address_def_3;
  assign bar_def[4] = base_address_def_4;
  assign bar_def[5] = base_address_def_5;

  assign word_addr = {cfg_addr_in[7:2], 2'b00};
  assign take      = (state_q == PCIH_IDLE) && (cfg_rd_in || cfg_wr_in);

  // access strobes for the read path and the writable header words
  assign rd_take = take && cfg_rd_in;
  assign wr_take = take && cfg_wr_in;
  assign wr_cmd  = wr_take && word_hit(cfg_addr_in, `PCIH_OFF_CMDSTAT);
  assign wr_misc = wr_take && word_hit(cfg_addr_in, `PCIH_OFF_MISC);
  assign wr_intr = wr_take && word_hit(cfg_addr_in, `PCIH_OFF_INTR);

  // access sequencer: a taken request is answered one cycle later
  always_comb begin
    state_d = state_q;
    case (state_q)
      PCIH_IDLE: begin
        if (take) begin
          state_d = PCIH_RESP;
        end
      end
      PCIH_RESP: begin
        state_d = PCIH_IDLE;
      end
      default: begin
        state_d = PCIH_IDLE;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_q <= PCIH_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // status word assembled straight from the configuration inputs
  always_comb begin
    status_w = 16'h0000;
    status_w[`PCIH_ST_CAP] = cap_list_ena_in;
    status_w[`PCIH_ST_66] = fast_clock_capable_input;
    status_w[`PCIH_ST_FB2B] = back_to_back_capable_input;
    status_w[`PCIH_ST_DEVSEL_LO +: 2] = decode_speed_in;
  end

  // bar write strobes
  generate
    for (genvar g = 0; g < 6; g++) begin : g_bar_wr
      assign bar_wr[g] = wr_take && word_hit(cfg_addr_in, 8'(`PCIH_OFF_BASE_ADDRESS_0 + 4 * g));
    end
  endgenerate

  // base address register pairs
  generate
    for (genvar p = 0; p < 3; p++) begin : g_bar
      pcih_bar_pair u_pair (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .def_lo_in  (bar_def[2*p]),
        .def_hi_in  (bar_def[2*p+1]),
        .wr_lo_in   (bar_wr[2*p]),
        .wr_hi_in   (bar_wr[2*p+1]),
        .wdata_in   (cfg_wdata_in),
        .be_in      (cfg_be_in),
        .rd_lo_out  (bar_rd[2*p]),
        .rd_hi_out  (bar_rd[2*p+1])
      );
    end
  endgenerate

  // header words assembled from the configuration inputs, the code parameters and the host-written fields
  assign lat_timer_rd = hw_lat_timer_ena_in ? hw_lat_timer_in : lat_timer_q;
  assign id_word      = {DEVICE_CODE, VENDOR_CODE};
  assign cmdstat_word = {status_w, command_q};
  assign class_word   = {class_code_in, revision_code_input};
  assign misc_word    = {16'h0000, lat_timer_rd, cache_line_q};
  assign subsys_word  = {SUB_DEVICE_CODE, SUB_VENDOR_CODE};
  assign cap_word     = {24'h000000, cap_ptr_in};
  assign intr_word    = {min_grant_in, max_latency_in, int_pin_in, int_line_q};

  // read decode, reserved words read as zero
  always_comb begin
    rd_word = 32'h00000000;
    if (word_addr == `PCIH_OFF_ID) begin
      rd_word = id_word;
    end else if (word_addr == `PCIH_OFF_CMDSTAT) begin
      rd_word = cmdstat_word;
    end else if (word_addr == `PCIH_OFF_CLASS) begin
      rd_word = class_word;
    end else if (word_addr == `PCIH_OFF_MISC) begin
      rd_word = misc_word;
    end else if (word_addr == `PCIH_OFF_BASE_ADDRESS_0) begin
      rd_word = bar_rd[0];
    end else if (word_addr == `PCIH_OFF_BASE_ADDRESS_1) begin
      rd_word = bar_rd[1];
    end else if (word_addr == `PCIH_OFF_BASE_ADDRESS_2) begin
      rd_word = bar_rd[2];
    end else if (word_addr == `PCIH_OFF_BASE_ADDRESS_3) begin
      rd_word = bar_rd[3];
    end else if (word_addr == `PCIH_OFF_BASE_ADDRESS_4) begin
      rd_word = bar_rd[4];
    end else if (word_addr == `PCIH_OFF_BASE_ADDRESS_5) begin
      rd_word = bar_rd[5];
    end else if (word_addr == `PCIH_OFF_CIS) begin
      rd_word = cis_ptr_in;
    end else if (word_addr == `PCIH_OFF_SUBSYS) begin
      rd_word = subsys_word;
    end else if (word_addr == `PCIH_OFF_CAP) begin
      rd_word = cap_word;
    end else if (word_addr == `PCIH_OFF_INTR) begin
      rd_word = intr_word;
    end else begin
      rd_word = 32'h00000000;
    end
  end

  // read data held until the next taken request
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cfg_rdata_out <= 32'h00000000;
    end else if (rd_take) begin
      cfg_rdata_out <= rd_word;
    end else if (take) begin
      cfg_rdata_out <= 32'h00000000;
    end
  end

  // one-cycle answer to every taken request
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cfg_ack_out <= 1'b0;
    end else begin
      cfg_ack_out <= take;
    end
  end

  // writable command bits; status is input-derived and ignores writes
  assign cmd_merged = pcih_merge({16'h0000, command_q}, cfg_wdata_in, cfg_be_in,
                                 {16'h0000, `PCIH_CMD_WR_MASK});

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      command_q <= 16'h0000;
    end else if (wr_cmd) begin
      command_q <= cmd_merged[15:0];
    end
  end

  // cache line size, kept for the host
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cache_line_q <= 8'h00;
    end else if (wr_misc && cfg_be_in[0]) begin
      cache_line_q <= cfg_wdata_in[7:0];
    end
  end

  // latency timer, frozen while hardwired
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      lat_timer_q <= 8'h00;
    end else if (wr_misc && cfg_be_in[1] && !hw_lat_timer_ena_in) begin
      lat_timer_q <= cfg_wdata_in[15:8];
    end
  end

  // interrupt routing line, kept for the host
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      int_line_q <= 8'h00;
    end else if (wr_intr && cfg_be_in[0]) begin
      int_line_q <= cfg_wdata_in[7:0];
    end
  end

  // registered copy of the per-bar data width selection
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      bar_wide_out <= 6'h00;
    end else begin
      bar_wide_out <= wide_data_select_input;
    end
  end

  // open-drain data of the interrupt line is always low
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      inta_out <= 1'b0;
    end else begin
      inta_out <= 1'b0;
    end
  end

  // interrupt forwarding and acknowledge claim
  pcih_irq_iack u_irq (
    .ref_clk_in       (ref_clk_in),
    .srst_in          (srst_in),
    .int_pin_in       (int_pin_in),
    .l_interrupt_n_in (l_interrupt_n_in),
    .intx_disable_in  (command_q[`PCIH_CMD_INTX_DIS]),
    .iack_ena_in      (iack_ena_in),
    .cmd_valid_in     (cmd_valid_in),
    .bus_cmd_in       (bus_cmd_in),
    .inta_oe_out      (inta_oe_out),
    .iack_claim_out   (iack_claim_out)
  );
endmodule : pcih_top

/* pkg/pcih_cfg.svh */
// constants for the pci configuration header port
`ifndef PCIH_CFG_SVH
`define PCIH_CFG_SVH
`define PCIH_OFF_ID       8'h00
`define PCIH_OFF_CMDSTAT  8'h04
`define PCIH_OFF_CLASS    8'h08
`define PCIH_OFF_MISC     8'h0C
`define PCIH_OFF_BASE_ADDRESS_0     8'h10
`define PCIH_OFF_BASE_ADDRESS_1     8'h14
`define PCIH_OFF_BASE_ADDRESS_2     8'h18
`define PCIH_OFF_BASE_ADDRESS_3     8'h1C
`define PCIH_OFF_BASE_ADDRESS_4     8'h20
`define PCIH_OFF_BASE_ADDRESS_5     8'h24
`define PCIH_OFF_CIS      8'h28
`define PCIH_OFF_SUBSYS   8'h2C
`define PCIH_OFF_CAP      8'h34
`define PCIH_OFF_INTR     8'h3C
`define PCIH_CMD_WR_MASK  16'h0747
`define PCIH_CMD_INTX_DIS 10
`define PCIH_ST_CAP       4
`define PCIH_ST_66        5
`define PCIH_ST_FB2B      7
`define PCIH_ST_DEVSEL_LO 9
`define PCIH_BAR_UNUSED   32'h00000002
`define PCIH_BAR_TYPE_64  2'b10
`define PCIH_PIN_INTA     8'h01
`define PCIH_BUS_CMD_IACK 4'h0
`endif

/* pkg/pcih_pkg.sv */
// types and shared helpers for the pci configuration header port
package pcih_pkg;
  typedef enum logic [1:0] {
    PCIH_IDLE = 2'b01,
    PCIH_RESP = 2'b10
  } pcih_state_t;

  typedef logic [31:0] pcih_word_t;

  // byte-lane merge of write data into a stored word, limited to writable bits
  function automatic pcih_word_t pcih_merge(input pcih_word_t old_w, input pcih_word_t new_w,
                                            input logic [3:0] be, input pcih_word_t wmask);
    pcih_word_t r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    pcih_merge = (r & wmask) | (old_w & ~wmask);
  endfunction : pcih_merge
endpackage : pcih_pkg

/* logic/pcih_bar_pair.sv */
// one even/odd pair of base address registers with 64-bit pairing
`timescale 1ns/100ps
`include "pcih_cfg.svh"
module pcih_bar_pair
  import pcih_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  input  wire pcih_word_t  def_lo_in,
  input  wire pcih_word_t  def_hi_in,
  input  wire logic        wr_lo_in,
  input  wire logic        wr_hi_in,
  input  wire pcih_word_t  wdata_in,
  input  wire logic [3:0]  be_in,
  output pcih_word_t       rd_lo_out,
  output pcih_word_t       rd_hi_out
);
  pcih_word_t lo_q;
  pcih_word_t hi_q;
  pcih_word_t lo_mask;
  pcih_word_t hi_mask;
  pcih_word_t lo_type;
  pcih_word_t hi_type;
  logic       pair_64;

  // writable address bits and constant type bits of one definition
  function automatic pcih_word_t bar_mask(input pcih_word_t d);
    if (d == `PCIH_BAR_UNUSED) begin
      bar_mask = 32'h00000000;
    end else if (d[0]) begin
      bar_mask = {d[31:2], 2'b00};
    end else begin
      bar_mask = {d[31:4], 4'h0};
    end
  endfunction : bar_mask

  function automatic pcih_word_t bar_type(input pcih_word_t d);
    if (d == `PCIH_BAR_UNUSED) begin
      bar_type = 32'h00000000;
    end else if (d[0]) begin
      bar_type = {30'h0, d[1:0]};
    end else begin
      bar_type = {28'h0, d[3:0]};
    end
  endfunction : bar_type

  always_comb begin
    pair_64 = !def_lo_in[0] && (def_lo_in[2:1] == `PCIH_BAR_TYPE_64) && (def_lo_in != `PCIH_BAR_UNUSED);
    lo_mask = bar_mask(def_lo_in);
    lo_type = bar_type(def_lo_in);
    hi_mask = pair_64 ? def_hi_in : bar_mask(def_hi_in);
    hi_type = pair_64 ? 32'h00000000 : bar_type(def_hi_in);
    rd_lo_out = (lo_q & lo_mask) | lo_type;
    rd_hi_out = (hi_q & hi_mask) | hi_type;
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      lo_q <= 32'h00000000;
    end else if (wr_lo_in) begin
      lo_q <= pcih_merge(lo_q, wdata_in, be_in, lo_mask);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      hi_q <= 32'h00000000;
    end else if (wr_hi_in) begin
      hi_q <= pcih_merge(hi_q, wdata_in, be_in, hi_mask);
    end
  end
endmodule : pcih_bar_pair

/* logic/pcih_irq_iack.sv */
// interrupt forwarding and interrupt acknowledge claim
`timescale 1ns/100ps
`include "pcih_cfg.svh"
module pcih_irq_iack
  import pcih_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  input  wire logic [7:0]  int_pin_in,
  input  wire logic        l_interrupt_n_in,
  input  wire logic        intx_disable_in,
  input  wire logic        iack_ena_in,
  input  wire logic        cmd_valid_in,
  input  wire logic [3:0]  bus_cmd_in,
  output logic             inta_oe_out,
  output logic             iack_claim_out
);
  // inta is open drain: oe high pulls the line low
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      inta_oe_out <= 1'b0;
    end else begin
      inta_oe_out <= (int_pin_in == `PCIH_PIN_INTA) && !l_interrupt_n_in && !intx_disable_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      iack_claim_out <= 1'b0;
    end else begin
      iack_claim_out <= cmd_valid_in && (bus_cmd_in == `PCIH_BUS_CMD_IACK) && iack_ena_in;
    end
  end
endmodule : pcih_irq_iack

/* tb/pcih_props.sv */
// concurrent checks on the configuration header port
`timescale 1ns/100ps
module pcih_props (
  input wire logic        ref_clk_in,
  input wire logic        srst_in,
  input wire logic        cfg_rd_in,
  input wire logic        cfg_wr_in,
  input wire logic [7:0]  cfg_addr_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic        cfg_ack_out,
  input wire logic        cmd_valid_in,
  input wire logic [3:0]  bus_cmd_in,
  input wire logic        iack_ena_in,
  input wire logic        iack_claim_out,
  input wire logic        l_interrupt_n_in,
  input wire logic [7:0]  int_pin_in,
  input wire logic        inta_out,
  input wire logic        inta_oe_out,
  input wire logic [7:0]  revision_code_input,
  input wire logic [23:0] class_code_in,
  input wire logic [5:0]  wide_data_select_input,
  input wire logic [5:0]  bar_wide_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);

  sequence s_take;
    (cfg_rd_in || cfg_wr_in) && !cfg_ack_out;
  endsequence
  sequence s_rd_class;
    s_take ##0 (cfg_rd_in && !cfg_wr_in && cfg_addr_in[7:2] == 6'h02);
  endsequence

  AST_ACK_TAKE: assert property (s_take |=> cfg_ack_out)
    else $error("no answer to a taken request");
  AST_ACK_CAUSE: assert property (cfg_ack_out |-> $past(cfg_rd_in || cfg_wr_in))
    else $error("answer without request");
  AST_ACK_PULSE: assert property (cfg_ack_out |=> !cfg_ack_out)
    else $error("answer longer than one cycle");
  AST_RD_HOLD: assert property (!cfg_ack_out |-> $stable(cfg_rdata_out))
    else $error("read data moved without answer");
  AST_CLASS: assert property (s_rd_class |=> cfg_rdata_out == {class_code_in, revision_code_input})
    else $error("class and revision word wrong");
  AST_IACK_CLAIM: assert property (cmd_valid_in && bus_cmd_in == 4'h0 && iack_ena_in |=> iack_claim_out)
    else $error("acknowledge command not claimed");
  AST_IACK_CAUSE: assert property (iack_claim_out |-> $past(cmd_valid_in && bus_cmd_in == 4'h0 && iack_ena_in))
    else $error("claim without enabled acknowledge command");
  AST_INTA_OE: assert property (inta_oe_out |-> $past(int_pin_in == 8'h01 && !l_interrupt_n_in))
    else $error("interrupt driven without request");
  AST_INTA_LOW: assert property (inta_oe_out |-> !inta_out)
    else $error("interrupt line driven high");
  AST_WIDE: assert property (!$past(srst_in) |-> bar_wide_out == $past(wide_data_select_input))
    else $error("width copy wrong");
endmodule : pcih_props

bind pcih_top pcih_props u_props (
  .ref_clk_in(ref_clk_in), .srst_in(srst_in), .cfg_rd_in(cfg_rd_in), .cfg_wr_in(cfg_wr_in),
  .cfg_addr_in(cfg_addr_in), .cfg_rdata_out(cfg_rdata_out), .cfg_ack_out(cfg_ack_out),
  .cmd_valid_in(cmd_valid_in), .bus_cmd_in(bus_cmd_in), .iack_ena_in(iack_ena_in),
  .iack_claim_out(iack_claim_out), .l_interrupt_n_in(l_interrupt_n_in), .int_pin_in(int_pin_in),
  .inta_out(inta_out), .inta_oe_out(inta_oe_out), .revision_code_input(revision_code_input),
  .class_code_in(class_code_in), .wide_data_select_input(wide_data_select_input), .bar_wide_out(bar_wide_out)
);

/* tb/pcih_host.sv */
// host model issuing configuration cycles and bus commands
`timescale 1ns/100ps
module pcih_host (
  input  wire logic        ref_clk_in,
  input  wire logic        cfg_ack_in,
  input  wire logic [31:0] cfg_rdata_in,
  input  wire logic        iack_claim_in,
  output logic             cfg_rd_out,
  output logic             cfg_wr_out,
  output logic [7:0]       cfg_addr_out,
  output logic [3:0]       cfg_be_out,
  output logic [31:0]      cfg_wdata_out,
  output logic             cmd_valid_out,
  output logic [3:0]       bus_cmd_out
);
  initial begin
    cfg_rd_out = 1'b0;
    cfg_wr_out = 1'b0;
    cfg_addr_out = 8'h00;
    cfg_be_out = 4'h0;
    cfg_wdata_out = 32'h0;
    cmd_valid_out = 1'b0;
    bus_cmd_out = 4'hF;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
                      input int gap, output logic [31:0] q, output logic ok);
    int n;
    repeat (gap) @(posedge ref_clk_in);
    #1;
    cfg_rd_out = !w;
    cfg_wr_out = w;
    cfg_addr_out = a;
    cfg_be_out = b;
    cfg_wdata_out = d;
    ok = 1'b0;
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge ref_clk_in);
      ok = (cfg_ack_in === 1'b1);
    end
    q = cfg_rdata_in;
    #1;
    cfg_rd_out = 1'b0;
    cfg_wr_out = 1'b0;
    cfg_addr_out = ~a;
    cfg_wdata_out = ~d;
  endtask : xfer

  task automatic send_cmd(input logic [3:0] c, output logic cl);
    @(posedge ref_clk_in);
    #1;
    cmd_valid_out = 1'b1;
    bus_cmd_out = c;
    @(posedge ref_clk_in);
    #1;
    cmd_valid_out = 1'b0;
    bus_cmd_out = ~c;
    cl = iack_claim_in;
  endtask : send_cmd
endmodule : pcih_host

/* tb/testbench.sv */
// self-checking testbench for the configuration header port
`timescale 1ns/100ps
module testbench;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        rd_req, wr_req, cmd_v, ack, claim, oe, inta, cl, irq_n = 1'b1, iack_en = 1'b1;
  logic [7:0]  addr, rev = 8'h5A, cap_ptr = 8'h40, pin = 8'h01, lat = 8'h10, mgnt = 8'hFF, mlat = 8'h3C;
  logic [3:0]  be, cmd;
  logic [31:0] wd, rdat, q, cis = 32'h13579BDF;
  logic [23:0] cls = 24'h0C0320;
  logic [1:0]  ds = 2'b10;
  logic        cap_en = 1'b1, b2b = 1'b1, f66 = 1'b1, lat_en = 1'b1;
  logic [5:0]  wide = 6'h3F, wide_q;
  logic [31:0] def [6] = '{32'hFFFF000C, 32'hFFFFFFFF, 32'hFFFFFFF9, 32'hFFF00000, 32'h2, 32'h2};
  logic [31:0] exp_v [7];
  localparam logic [7:0] ADR [7] = '{8'h04, 8'h08, 8'h0C, 8'h28, 8'h30, 8'h34, 8'h3C};
  localparam logic [31:0] MSK [7] = '{32'hFFFF0000, 32'hFFFFFFFF, 32'h0000FF00, 32'hFFFFFFFF, 32'hFFFFFFFF,
                                      32'hFFFFFFFF, 32'hFFFFFF00};
  localparam logic [31:0] RST_BAR [6] = '{32'h0000000C, 32'h0, 32'h00000001, 32'h0, 32'h0, 32'h0};
  int          fail_count = 0, n_tests = 0;

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  pcih_top dut (
    .ref_clk_in(ref_clk), .srst_in(srst), .cfg_rd_in(rd_req), .cfg_wr_in(wr_req), .cfg_addr_in(addr),
    .cfg_be_in(be), .cfg_wdata_in(wd), .cfg_rdata_out(rdat), .cfg_ack_out(ack), .cmd_valid_in(cmd_v),
    .bus_cmd_in(cmd), .iack_claim_out(claim), .l_interrupt_n_in(irq_n), .inta_out(inta), .inta_oe_out(oe),
    .revision_code_input(rev), .class_code_in(cls), .decode_speed_in(ds), .cap_list_ena_in(cap_en),
    .cap_ptr_in(cap_ptr), .cis_ptr_in(cis), .back_to_back_capable_input(b2b), .iack_ena_in(iack_en),
    .int_pin_in(pin), .hw_lat_timer_in(lat), .hw_lat_timer_ena_in(lat_en), .min_grant_in(mgnt),
    .max_latency_in(mlat), .fast_clock_capable_input(f66), .wide_data_select_input(wide),
    .base_address_def_0(def[0]), .base_address_def_1(def[1]), .base_address_def_2(def[2]),
    .base_address_def_3(def[3]), .base_address_def_4(def[4]), .base_address_def_5(def[5]),
    .bar_wide_out(wide_q)
  );
  pcih_host host (
    .ref_clk_in(ref_clk), .cfg_ack_in(ack), .cfg_rdata_in(rdat), .iack_claim_in(claim), .cfg_rd_out(rd_req),
    .cfg_wr_out(wr_req), .cfg_addr_out(addr), .cfg_be_out(be), .cfg_wdata_out(wd), .cmd_valid_out(cmd_v),
    .bus_cmd_out(cmd)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  task automatic access(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
                        output logic [31:0] r);
    logic ok;
    host.xfer(w, a, b, d, w ? 3 : 1, r, ok);
    if (!ok) begin
      fail_count++;
      test_done();
    end
  endtask : access

  initial begin
    exp_v = '{{5'h0, ds, 1'b0, b2b, 1'b0, f66, cap_en, 4'h0, 16'h0}, {cls, rev}, {16'h0, lat, 8'h0}, cis,
              32'h0, {24'h0, cap_ptr}, {mgnt, mlat, pin, 8'h0}};
    repeat (5) @(posedge ref_clk);
    #1 srst = 1'b0;
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 7; i++) begin
        access(1'b0, ADR[i], 4'h0, 32'h0, q);
        check(q & MSK[i], exp_v[i]);
        access(1'b1, ADR[i], (i == 0) ? 4'hC : 4'hE, 32'hFFFFFFFF, q);
      end
    end
    for (int i = 0; i < 6; i++) begin
      access(1'b0, 8'h10 + 8'(4 * i), 4'h0, 32'h0, q);
      check(q, RST_BAR[i]);
      access(1'b1, 8'h10 + 8'(4 * i), 4'hF, 32'hFFFFFFFF, q);
      access(1'b0, 8'h10 + 8'(4 * i), 4'h0, 32'h0, q);
      check(q, (i < 4) ? def[i] : 32'h0);
    end
    access(1'b1, 8'h13, 4'h8, 32'h0, q);
    access(1'b0, 8'h10, 4'h0, 32'h0, q);
    check(q, 32'h00FF000C);
    check({26'h0, wide_q}, 32'h0000003F);
    irq_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check({30'h0, oe, inta}, 32'h2);
    access(1'b1, 8'h04, 4'h2, 32'h00000400, q);
    repeat (2) @(posedge ref_clk);
    #1 check({31'h0, oe}, 32'h0);
    access(1'b1, 8'h04, 4'h2, 32'h0, q);
    repeat (2) @(posedge ref_clk);
    #1 check({31'h0, oe}, 32'h1);
    irq_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 check({31'h0, oe}, 32'h0);
    for (int e = 0; e < 2; e++) begin
      srst = 1'b1;
      iack_en = e[0];
      lat_en = e[0];
      repeat (2) @(posedge ref_clk);
      #1 srst = 1'b0;
      access(1'b1, 8'h0C, 4'h2, 32'h0000A500, q);
      access(1'b0, 8'h0C, 4'h0, 32'h0, q);
      check(q, e[0] ? {16'h0, lat, 8'h0} : 32'h0000A500);
      for (int c = 0; c < 16; c++) begin
        host.send_cmd(4'(c), cl);
        check({31'h0, cl}, {31'h0, e[0] && c == 0});
      end
    end
    test_done();
  end
endmodule : testbench
